// file: core/erf_pkg.sv
// Purpose: Shared constants and types for the embedded RAM and FIFO block.
// Assumes: One clock domain and an Avalon-MM register slave.
// Notes:   Shapes with 9, 18 and 36 bit words span all 18432 stored bits.
package erf_pkg;
  localparam int MEM_BITS = 18432;
  localparam int WMAX     = 36;
  localparam int AW       = 14;
  localparam int LW       = 15;
  localparam int CW       = 11;
  localparam int IRQ_W    = 4;

  typedef enum logic [2:0] {
    ERF_X1  = 3'b000,
    ERF_X2  = 3'b001,
    ERF_X4  = 3'b010,
    ERF_X9  = 3'b011,
    ERF_X18 = 3'b100,
    ERF_X36 = 3'b101
  } erf_shape_t;

  typedef enum logic [1:0] {
    ERF_SINGLE      = 2'b00,
    ERF_TRUE_DUAL   = 2'b01,
    ERF_PSEUDO_DUAL = 2'b10,
    ERF_FIFO        = 2'b11
  } erf_mode_t;

  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL       = 4'h0;
  localparam logic [3:0] OFS_STATUS     = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK   = 4'hC;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WT_BIT   = 2;
  localparam int CTRL_OREG_BIT = 3;
  localparam int CTRL_SHA_LSB  = 4;
  localparam int CTRL_SHB_LSB  = 7;
  localparam int CTRL_LOCK_BIT = 10;
  localparam logic [CW-1:0] CTRL_RESET = 11'h000;

  // Status register fields.
  localparam int ST_CFG_ERR   = 0;
  localparam int ST_FULL      = 1;
  localparam int ST_AFULL     = 2;
  localparam int ST_EMPTY     = 3;
  localparam int ST_AEMPTY    = 4;
  localparam int ST_LEVEL_LSB = 16;

  // Interrupt status bits.
  localparam int IRQ_WR_REFUSED = 0;
  localparam int IRQ_RD_REFUSED = 1;
  localparam int IRQ_BECAME_FULL  = 2;
  localparam int IRQ_BECAME_EMPTY = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

  // FIFO capacity in bits and almost thresholds in words.
  localparam logic [LW-1:0] CAP_NARROW         = 15'h4000;
  localparam logic [LW-1:0] CAP_WIDE           = 15'h4800;
  localparam logic [LW-1:0] ALMOST_FULL_WORDS  = 15'h0004;
  localparam logic [LW-1:0] ALMOST_EMPTY_WORDS = 15'h0004;

  function automatic logic [LW-1:0] shape_width(input erf_shape_t s);
    case (s)
      ERF_X1:  return 15'h0001;
      ERF_X2:  return 15'h0002;
      ERF_X4:  return 15'h0004;
      ERF_X9:  return 15'h0009;
      ERF_X18: return 15'h0012;
      default: return 15'h0024;
    endcase
  endfunction : shape_width

  function automatic logic [LW-1:0] shape_depth(input erf_shape_t s);
    case (s)
      ERF_X1:  return 15'h4000;
      ERF_X2:  return 15'h2000;
      ERF_X4:  return 15'h1000;
      ERF_X9:  return 15'h0800;
      ERF_X18: return 15'h0400;
      default: return 15'h0200;
    endcase
  endfunction : shape_depth

  function automatic logic [LW-1:0] shape_cap(input erf_shape_t s);
    return (s >= ERF_X9) ? CAP_WIDE : CAP_NARROW;
  endfunction : shape_cap
endpackage : erf_pkg

// file: core/erf_ram.sv
// Purpose: Bit-addressed storage array with two registered access ports.
// Assumes: Requests come from logic on the same clock.
// Notes:   Port B wins when both ports write the same bit in one cycle.
`timescale 1ns/1ps
`default_nettype none
module erf_ram #(
  parameter logic [erf_pkg::MEM_BITS-1:0] INIT_BITS = '0
) (
  // Clock and reset.
  input  wire logic                                 clock,
  input  wire logic                                 sys_rst,
  // Port requests, index 0 is port A and index 1 is port B.
  input  wire logic [1:0]                           en,
  input  wire logic [1:0]                           we,
  input  wire erf_pkg::erf_shape_t [1:0]            shape,
  input  wire logic [1:0][erf_pkg::AW-1:0]          addr,
  input  wire logic [1:0][erf_pkg::WMAX-1:0]        wdata,
  // Registered request view and array read word.
  output logic [1:0]                                rd_q,
  output logic [1:0]                                wr_q,
  output logic [1:0][erf_pkg::WMAX-1:0]             wdata_q,
  output logic [1:0][erf_pkg::WMAX-1:0]             rd_word
);
  typedef struct packed {
    logic [erf_pkg::MEM_BITS-1:0]          mem;
    logic [1:0]                            en;
    logic [1:0]                            we;
    erf_pkg::erf_shape_t [1:0]             shape;
    logic [1:0][erf_pkg::AW-1:0]           addr;
    logic [1:0][erf_pkg::WMAX-1:0]         wdata;
  } erf_ram_state_t;

  localparam int REST_BITS = $bits(erf_ram_state_t) - erf_pkg::MEM_BITS;
  localparam erf_ram_state_t RST_STATE = {INIT_BITS, {REST_BITS{1'b0}}};

  erf_ram_state_t st;
  erf_ram_state_t next_st;

  function automatic logic [19:0] bit_base(input erf_pkg::erf_shape_t s,
                                           input logic [erf_pkg::AW-1:0] a);
    return 20'(a) * 20'(erf_pkg::shape_width(s));
  endfunction : bit_base

  function automatic logic in_range(input erf_pkg::erf_shape_t s,
                                    input logic [erf_pkg::AW-1:0] a);
    return {1'b0, a} < erf_pkg::shape_depth(s);
  endfunction : in_range

  always_comb begin : next_state
    logic [19:0] base;
    base    = '0;
    next_st = st;
    for (int p = 0; p < 2; p++) begin
      // Address and data are captured before they reach the array.
      next_st.en[p]    = en[p];
      next_st.we[p]    = en[p] & we[p];
      next_st.shape[p] = shape[p];
      next_st.addr[p]  = addr[p];
      next_st.wdata[p] = wdata[p];
      base = bit_base(st.shape[p], st.addr[p]);
      if (st.we[p] && in_range(st.shape[p], st.addr[p])) begin
        for (int i = 0; i < erf_pkg::WMAX; i++) begin
          if (i < int'(erf_pkg::shape_width(st.shape[p]))) begin
            next_st.mem[int'(base) + i] = st.wdata[p][i];
          end
        end
      end
    end
  end

  always_comb begin : read_words
    logic [19:0] rbase;
    rbase   = '0;
    rd_word = '0;
    for (int p = 0; p < 2; p++) begin
      rbase = bit_base(st.shape[p], st.addr[p]);
      if (in_range(st.shape[p], st.addr[p])) begin
        for (int i = 0; i < erf_pkg::WMAX; i++) begin
          if (i < int'(erf_pkg::shape_width(st.shape[p]))) begin
            rd_word[p][i] = st.mem[int'(rbase) + i];
          end
        end
      end
    end
  end

  // The preload image is reloaded by every reset.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign rd_q    = st.en & ~st.we;
  assign wr_q    = st.we;
  assign wdata_q = st.wdata;
endmodule : erf_ram
`default_nettype wire

// file: core/erf_embedded_ram_block.sv
// Purpose: Embedded RAM block with RAM, ROM and FIFO modes.
// Assumes: User logic and the register bus share one running clock.
// Notes:   FIFO write and read sides both run on that clock.
//
// Overview of operation
// - Shapes 16Kx1 to 512x36; 512x36 refused in true dual-port mode.
// - Each port of a multi-port mode has its own data width.
// - Bits map linearly, word zero LSB first, same for every port.
// - Contents preload at configuration; locked writes make a ROM.
// - Address and write data are registered at the array input.
// - Optional output register adds exactly one clock of read delay.
// - Normal mode: output changes only on reads, never on writes.
// - Write-through mode: written data appears on the same port.
// - FIFO has write and read ports with their own enables.
// - FIFO derives full, almost full, empty, almost empty itself.
// - Full and almost full are registered on the write side clock.
// - Empty and almost empty are registered on the read side clock.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module erf_embedded_ram_block #(
  parameter logic [erf_pkg::MEM_BITS-1:0] INIT_BITS = '0
) (
  // Clock and reset.
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  // Avalon-MM register slave.
  input  wire logic [3:0]                    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest,
  output logic                               irq,
  // RAM port A.
  input  wire logic                          a_en,
  input  wire logic                          a_we,
  input  wire logic [erf_pkg::AW-1:0]        a_addr,
  input  wire logic [erf_pkg::WMAX-1:0]      a_wdata,
  output logic [erf_pkg::WMAX-1:0]           a_rdata,
  // RAM port B.
  input  wire logic                          b_en,
  input  wire logic                          b_we,
  input  wire logic [erf_pkg::AW-1:0]        b_addr,
  input  wire logic [erf_pkg::WMAX-1:0]      b_wdata,
  output logic [erf_pkg::WMAX-1:0]           b_rdata,
  // FIFO write side.
  input  wire logic [erf_pkg::WMAX-1:0]      fifo_wdata,
  input  wire logic                          write_clock_enable,
  input  wire logic                          fifo_write_enable,
  output logic                               fifo_full,
  output logic                               fifo_almost_full,
  // FIFO read side.
  input  wire logic                          read_clock_enable,
  input  wire logic                          read_request,
  output logic [erf_pkg::WMAX-1:0]           fifo_rdata,
  output logic                               fifo_empty,
  output logic                               fifo_almost_empty
);
  typedef struct packed {
    logic [erf_pkg::CW-1:0]          ctrl;
    logic [erf_pkg::IRQ_W-1:0]       irq_st;
    logic [erf_pkg::IRQ_W-1:0]       irq_mask;
    logic                            ack;
    logic [31:0]                     rdata;
    logic [erf_pkg::AW-1:0]          wa;
    logic [erf_pkg::AW-1:0]          ra;
    logic [erf_pkg::LW-1:0]          level;
    logic                            full;
    logic                            afull;
    logic                            empty;
    logic                            aempty;
    logic [1:0][erf_pkg::WMAX-1:0]   d1;
    logic [1:0][erf_pkg::WMAX-1:0]   d2;
  } erf_top_state_t;

  localparam erf_top_state_t RST_STATE = '{
    ctrl:     erf_pkg::CTRL_RESET,
    irq_mask: erf_pkg::IRQ_MASK_RESET,
    empty:    1'b1,
    aempty:   1'b1,
    default:  '0
  };

  erf_top_state_t st;
  erf_top_state_t next_st;

  // Storage array connections.
  logic [1:0]                        ram_en;
  logic [1:0]                        ram_we;
  erf_pkg::erf_shape_t [1:0]         ram_shape;
  logic [1:0][erf_pkg::AW-1:0]       ram_addr;
  logic [1:0][erf_pkg::WMAX-1:0]     ram_wdata;
  logic [1:0]                        ram_rd_q;
  logic [1:0]                        ram_wr_q;
  logic [1:0][erf_pkg::WMAX-1:0]     ram_wdata_q;
  logic [1:0][erf_pkg::WMAX-1:0]     ram_rd_word;

  // Decoded configuration.
  erf_pkg::erf_mode_t     mode;
  erf_pkg::erf_shape_t    sha;
  erf_pkg::erf_shape_t    shb;
  logic                   write_through;
  logic                   out_reg;
  logic                   lock;
  logic                   cfg_err;
  logic                   fifo_on;
  logic [erf_pkg::LW-1:0] ww;
  logic [erf_pkg::LW-1:0] rw;
  logic [erf_pkg::LW-1:0] cap;

  // FIFO request decode.
  logic                   wr_ask;
  logic                   rd_ask;
  logic                   wr_acc;
  logic                   rd_acc;
  logic [erf_pkg::IRQ_W-1:0] events;
  logic                   bus_req;

  assign mode    = erf_pkg::erf_mode_t'(st.ctrl[erf_pkg::CTRL_MODE_LSB +: 2]);
  assign sha     = erf_pkg::erf_shape_t'(st.ctrl[erf_pkg::CTRL_SHA_LSB +: 3]);
  assign shb     = erf_pkg::erf_shape_t'(st.ctrl[erf_pkg::CTRL_SHB_LSB +: 3]);
  assign write_through = st.ctrl[erf_pkg::CTRL_WT_BIT];
  assign out_reg = st.ctrl[erf_pkg::CTRL_OREG_BIT];
  assign lock    = st.ctrl[erf_pkg::CTRL_LOCK_BIT];
  assign ww      = erf_pkg::shape_width(sha);
  assign rw      = erf_pkg::shape_width(shb);
  assign cap     = erf_pkg::shape_cap(sha);

  // The 36-bit shape has no true dual-port form, and a FIFO needs both
  // sides to see the same capacity in bits.
  assign cfg_err = ((mode == erf_pkg::ERF_TRUE_DUAL) &&
                    (sha == erf_pkg::ERF_X36 || shb == erf_pkg::ERF_X36)) ||
                   ((mode == erf_pkg::ERF_FIFO) &&
                    (erf_pkg::shape_cap(shb) != cap));
  assign fifo_on = (mode == erf_pkg::ERF_FIFO) && !cfg_err;

  assign wr_ask  = write_clock_enable & fifo_write_enable;
  assign rd_ask  = read_clock_enable & read_request;
  assign wr_acc  = fifo_on & wr_ask & ~st.full;
  assign rd_acc  = fifo_on & rd_ask & ~st.empty;

  // Port steering per mode.
  always_comb begin
    ram_shape[0] = sha;
    ram_shape[1] = shb;
    ram_en       = '0;
    ram_we       = '0;
    ram_addr[0]  = a_addr;
    ram_addr[1]  = b_addr;
    ram_wdata[0] = a_wdata;
    ram_wdata[1] = b_wdata;
    case (mode)
      erf_pkg::ERF_SINGLE: begin
        ram_en[0] = a_en;
        ram_we[0] = a_we & ~lock;
      end
      erf_pkg::ERF_TRUE_DUAL: begin
        ram_en = {b_en, a_en};
        ram_we = {b_we, a_we} & {2{~lock}};
      end
      erf_pkg::ERF_PSEUDO_DUAL: begin
        ram_en    = {b_en, a_en};
        ram_we[0] = a_we & ~lock;
      end
      default: begin
        ram_en       = {rd_acc, wr_acc};
        ram_we[0]    = wr_acc;
        ram_addr[0]  = st.wa;
        ram_addr[1]  = st.ra;
        ram_wdata[0] = fifo_wdata;
      end
    endcase
    if (cfg_err) begin
      ram_en = '0;
      ram_we = '0;
    end
  end

  // Next state: register bus, FIFO pointers and flags, read data path.
  always_comb begin
    logic [erf_pkg::LW-1:0] nlevel;
    logic [erf_pkg::LW-1:0] free;
    logic [erf_pkg::LW-1:0] nptr;
    logic [erf_pkg::IRQ_W-1:0] clr;
    nlevel  = '0;
    free    = '0;
    nptr    = '0;
    clr     = '0;
    next_st = st;

    // One wait cycle per access; the answer comes in the second cycle.
    next_st.ack = bus_req & ~st.ack;
    if (avs_read && !st.ack) begin
      if (avs_address == erf_pkg::OFS_CTRL) begin
        next_st.rdata = {{(32 - erf_pkg::CW){1'b0}}, st.ctrl};
      end else if (avs_address == erf_pkg::OFS_STATUS) begin
        next_st.rdata = '0;
        next_st.rdata[erf_pkg::ST_CFG_ERR] = cfg_err;
        next_st.rdata[erf_pkg::ST_FULL]    = st.full;
        next_st.rdata[erf_pkg::ST_AFULL]   = st.afull;
        next_st.rdata[erf_pkg::ST_EMPTY]   = st.empty;
        next_st.rdata[erf_pkg::ST_AEMPTY]  = st.aempty;
        next_st.rdata[erf_pkg::ST_LEVEL_LSB +: erf_pkg::LW] = st.level;
      end else if (avs_address == erf_pkg::OFS_IRQ_STATUS) begin
        next_st.rdata = {{(32 - erf_pkg::IRQ_W){1'b0}}, st.irq_st};
      end else if (avs_address == erf_pkg::OFS_IRQ_MASK) begin
        next_st.rdata = {{(32 - erf_pkg::IRQ_W){1'b0}}, st.irq_mask};
      end else begin
        next_st.rdata = '0;
      end
    end
    if (avs_write && st.ack) begin
      if (avs_address == erf_pkg::OFS_CTRL) begin
        next_st.ctrl = avs_writedata[erf_pkg::CW-1:0];
      end else if (avs_address == erf_pkg::OFS_IRQ_STATUS) begin
        clr = avs_writedata[erf_pkg::IRQ_W-1:0];
      end else if (avs_address == erf_pkg::OFS_IRQ_MASK) begin
        next_st.irq_mask = avs_writedata[erf_pkg::IRQ_W-1:0];
      end
    end
    // FIFO pointers; leaving FIFO mode empties it.
    if (fifo_on) begin
      nlevel = st.level;
      if (wr_acc) begin
        nptr = {1'b0, st.wa} + 15'h0001;
        next_st.wa = (nptr == erf_pkg::shape_depth(sha)) ? '0 :
                     nptr[erf_pkg::AW-1:0];
        nlevel = nlevel + ww;
      end
      if (rd_acc) begin
        nptr = {1'b0, st.ra} + 15'h0001;
        next_st.ra = (nptr == erf_pkg::shape_depth(shb)) ? '0 :
                     nptr[erf_pkg::AW-1:0];
        nlevel = nlevel - rw;
      end
    end else begin
      next_st.wa = '0;
      next_st.ra = '0;
    end
    free          = cap - nlevel;
    next_st.level = nlevel;
    next_st.full  = fifo_on && (free < ww);
    next_st.afull = fifo_on &&
                    (free < erf_pkg::ALMOST_FULL_WORDS * ww);
    next_st.empty  = !fifo_on || (nlevel < rw);
    next_st.aempty = !fifo_on ||
                     (nlevel < erf_pkg::ALMOST_EMPTY_WORDS * rw);

    // Became events follow the new flags, refusals the current ones, and a new event wins over a clear.
    events[erf_pkg::IRQ_WR_REFUSED]   = fifo_on & wr_ask & st.full;
    events[erf_pkg::IRQ_RD_REFUSED]   = fifo_on & rd_ask & st.empty;
    events[erf_pkg::IRQ_BECAME_FULL]  = next_st.full & ~st.full;
    events[erf_pkg::IRQ_BECAME_EMPTY] = fifo_on & next_st.empty & ~st.empty;
    next_st.irq_st = (st.irq_st & ~clr) | events;

    // Read data: reads load, writes load only in write-through mode.
    for (int p = 0; p < 2; p++) begin
      if (ram_rd_q[p]) begin
        next_st.d1[p] = ram_rd_word[p];
      end else if (ram_wr_q[p] && write_through) begin
        next_st.d1[p] = ram_wdata_q[p];
      end
      next_st.d2[p] = st.d1[p];
    end
  end

  erf_ram #(
    .INIT_BITS (INIT_BITS)
  ) u_ram (
    .clock   (clock),
    .sys_rst (sys_rst),
    .en      (ram_en),
    .we      (ram_we),
    .shape   (ram_shape),
    .addr    (ram_addr),
    .wdata   (ram_wdata),
    .rd_q    (ram_rd_q),
    .wr_q    (ram_wr_q),
    .wdata_q (ram_wdata_q),
    .rd_word (ram_rd_word)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~st.ack;
  assign avs_readdata    = st.rdata;
  assign irq             = |(st.irq_st & st.irq_mask);

  // The output register selects the copy taken one clock later.
  assign a_rdata    = out_reg ? st.d2[0] : st.d1[0];
  assign b_rdata    = out_reg ? st.d2[1] : st.d1[1];
  assign fifo_rdata = b_rdata;

  assign fifo_full         = st.full;
  assign fifo_almost_full  = st.afull;
  assign fifo_empty        = st.empty;
  assign fifo_almost_empty = st.aempty;
endmodule : erf_embedded_ram_block
`default_nettype wire

// file: sim/erf_properties.sv
// Purpose: FIFO flag checks for the embedded RAM block.
// Assumes: One clock; reset asynchronous, active high.
// Notes:   A bus write may change mode and so clear full and set empty.
`timescale 1ns/1ps
`default_nettype none
module erf_checker (
  // Clock, reset and bus.
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic avs_write,
  // FIFO sides.
  input wire logic write_clock_enable,
  input wire logic fifo_write_enable,
  input wire logic fifo_full,
  input wire logic fifo_almost_full,
  input wire logic read_clock_enable,
  input wire logic read_request,
  input wire logic fifo_empty,
  input wire logic fifo_almost_empty
);
  wire wr_ok = write_clock_enable && fifo_write_enable;
  wire rd_ok = read_clock_enable && read_request;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_full_af; fifo_full |-> fifo_almost_full; endproperty
  a_full_af: assert property (p_full_af)
    else $error("full without almost full");
  property p_empty_ae; fifo_empty |-> fifo_almost_empty; endproperty
  a_empty_ae: assert property (p_empty_ae)
    else $error("empty without almost empty");
  property p_full_rise;
    $rose(fifo_full) |-> $past(fifo_almost_full) && $past(wr_ok);
  endproperty
  a_full_rise: assert property (p_full_rise)
    else $error("full rose without a write");
  property p_empty_rise;
    $rose(fifo_empty) && !$past(avs_write, 2)
      |-> $past(fifo_almost_empty) && $past(rd_ok);
  endproperty
  a_empty_rise: assert property (p_empty_rise)
    else $error("empty rose without a read");
  property p_fill; $fell(fifo_empty) |-> $past(wr_ok); endproperty
  a_fill: assert property (p_fill)
    else $error("empty fell without a write");
  property p_drain;
    $fell(fifo_full) && !$past(avs_write, 2) |-> $past(rd_ok);
  endproperty
  a_drain: assert property (p_drain)
    else $error("full fell without a read");
  property p_hold_full;
    fifo_full && !rd_ok && !avs_write && !$past(avs_write) |=> fifo_full;
  endproperty
  a_hold_full: assert property (p_hold_full)
    else $error("full dropped with no read");
  property p_hold_empty;
    fifo_empty && !wr_ok && !avs_write |=> fifo_empty;
  endproperty
  a_hold_empty: assert property (p_hold_empty)
    else $error("empty dropped with no write");
endmodule : erf_checker
bind erf_embedded_ram_block erf_checker u_chk (
  .clock(clock), .sys_rst(sys_rst), .avs_write(avs_write),
  .write_clock_enable(write_clock_enable),
  .fifo_write_enable(fifo_write_enable), .fifo_full(fifo_full),
  .fifo_almost_full(fifo_almost_full),
  .read_clock_enable(read_clock_enable), .read_request(read_request),
  .fifo_empty(fifo_empty), .fifo_almost_empty(fifo_almost_empty));
`default_nettype wire

// file: sim/erf_fabric_writer.sv
// Purpose: Fabric logic that pushes a run of words into the FIFO.
// Assumes: Started by a one-cycle pulse on start.
// Notes:   Clock enable is low on every other cycle of a run.
`timescale 1ns/1ps
`default_nettype none
module erf_fabric_writer #(
  parameter int COUNT = 513
) (
  // Clock, reset and job control.
  input  wire logic   clock,
  input  wire logic   sys_rst,
  input  wire logic   start,
  output logic        busy,
  // FIFO write side.
  output logic [35:0] fifo_wdata,
  output logic        write_clock_enable,
  output logic        fifo_write_enable
);
  logic [9:0] idx;
  logic       ph;
  // Write enable stays high while clock enable is low, so a write that
  // skips the clock enable would show up as a wrong or early word.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      idx <= 10'h000;
      ph <= 1'b0;
      fifo_wdata <= 36'h0;
      write_clock_enable <= 1'b0;
      fifo_write_enable <= 1'b0;
    end else begin
      write_clock_enable <= 1'b0;
      fifo_write_enable <= 1'b0;
      fifo_wdata <= ~fifo_wdata;
      if (start && !busy) begin
        busy <= 1'b1;
        idx <= 10'h000;
        ph <= 1'b0;
      end else if (busy) begin
        ph <= ~ph;
        fifo_write_enable <= 1'b1;
        write_clock_enable <= ph;
        fifo_wdata <= {4'h9, 22'h0, idx};
        if (ph) begin
          idx <= idx + 10'h001;
          busy <= (idx != 10'(COUNT - 1));
        end
      end
    end
  end
endmodule : erf_fabric_writer
`default_nettype wire

// file: sim/erf_embedded_ram_block_tb.sv
// Purpose: Self-checking bench for the embedded RAM block.
// Assumes: Preload image holds A5 in the lowest bits.
// Notes:   The FIFO is filled past full and drained past empty.
`timescale 1ns/1ps
`default_nettype none
module erf_embedded_ram_block_tb;
  logic        clock, sys_rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        a_en, a_we, b_en, b_we, start, busy;
  logic [13:0] a_addr, b_addr;
  logic [35:0] a_wdata, a_rdata, b_wdata, b_rdata, fifo_wdata, fifo_rdata;
  logic        write_clock_enable, fifo_write_enable, fifo_full;
  logic        fifo_almost_full, read_clock_enable, read_request;
  logic        fifo_empty, fifo_almost_empty;
  int          error_cnt, cmp_count, n;

  erf_embedded_ram_block #(.INIT_BITS(18432'hA5)) dut (.*);
  erf_fabric_writer #(.COUNT(513)) u_fab (.clock(clock),
    .sys_rst(sys_rst), .start(start), .busy(busy),
    .fifo_wdata(fifo_wdata), .write_clock_enable(write_clock_enable),
    .fifo_write_enable(fifo_write_enable));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] ad,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= ad;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) error_cnt++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [3:0] ad, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk({4'h0, q & m}, {4'h0, e});
  endtask : rdc

  task automatic acc(input logic pb, input logic w,
                     input logic [13:0] ad, input logic [35:0] d);
    @(posedge clock);
    if (pb) {b_en, b_we, b_addr, b_wdata} <= {1'b1, w, ad, d};
    else {a_en, a_we, a_addr, a_wdata} <= {1'b1, w, ad, d};
    @(posedge clock);
    {a_en, a_we, b_en, b_we} <= 4'h0;
    repeat (2) @(negedge clock);
  endtask : acc

  task automatic rd_fifo();
    @(posedge clock);
    {read_clock_enable, read_request} <= 2'b11;
    @(posedge clock);
    {read_clock_enable, read_request} <= 2'b00;
    repeat (3) @(negedge clock);
  endtask : rd_fifo

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  initial begin
    {error_cnt, cmp_count, n} = '0;
    sys_rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata} = '0;
    {start, read_clock_enable, read_request} = 3'h0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rdc(erf_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
    rdc(4'h2, 32'hFFFF_FFFF, 32'h0);
    acc(1'b0, 1'b0, 14'h7, 36'h0);
    chk(a_rdata, 36'h1);
    bus(1'b1, erf_pkg::OFS_CTRL, 32'h2D2);
    acc(1'b1, 1'b0, 14'h0, 36'h0);
    chk(b_rdata, 36'hA5);
    acc(1'b0, 1'b1, 14'h1, 36'h9_8765_4321);
    chk(a_rdata, 36'h1);
    acc(1'b0, 1'b0, 14'h1, 36'h0);
    chk(a_rdata, 36'h9_8765_4321);
    bus(1'b1, erf_pkg::OFS_CTRL, 32'h2DA);
    acc(1'b0, 1'b0, 14'h0, 36'h0);
    chk(a_rdata, 36'h9_8765_4321);
    @(negedge clock);
    chk(a_rdata, 36'hA5);
    bus(1'b1, erf_pkg::OFS_CTRL, 32'h2D6);
    acc(1'b0, 1'b1, 14'h2, 36'h1_2345_6789);
    chk(a_rdata, 36'h1_2345_6789);
    bus(1'b1, erf_pkg::OFS_CTRL, 32'h6D2);
    acc(1'b0, 1'b1, 14'h0, 36'hF_FFFF_FFFF);
    acc(1'b0, 1'b0, 14'h0, 36'h0);
    chk(a_rdata, 36'hA5);
    bus(1'b1, erf_pkg::OFS_CTRL, 32'h1C1);
    acc(1'b0, 1'b1, 14'h5, 36'h2_B3C5);
    acc(1'b1, 1'b0, 14'hA, 36'h0);
    chk(b_rdata, 36'h1C5);
    acc(1'b1, 1'b0, 14'hB, 36'h0);
    chk(b_rdata, 36'h159);
    bus(1'b1, erf_pkg::OFS_CTRL, 32'h2D1);
    rdc(erf_pkg::OFS_STATUS, 32'h1, 32'h1);
    bus(1'b1, erf_pkg::OFS_CTRL, 32'h2D3);
    rdc(erf_pkg::OFS_STATUS, 32'h1, 32'h0);
    bus(1'b1, erf_pkg::OFS_IRQ_MASK, 32'h1);
    @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while (busy !== 1'b0 && n < 3000);
    repeat (3) @(negedge clock);
    chk({33'h0, fifo_full, fifo_almost_full, fifo_empty}, 36'h6);
    rdc(erf_pkg::OFS_IRQ_STATUS, 32'hF, 32'h5);
    @(negedge clock);
    chk({35'h0, irq}, 36'h1);
    bus(1'b1, erf_pkg::OFS_IRQ_STATUS, 32'hF);
    @(negedge clock);
    chk({35'h0, irq}, 36'h0);
    @(posedge clock);
    read_request <= 1'b1;
    repeat (2) @(posedge clock);
    read_request <= 1'b0;
    @(negedge clock);
    chk({35'h0, fifo_full}, 36'h1);
    for (int i = 0; i < 512; i++) begin
      rd_fifo();
      chk(fifo_rdata, {4'h9, 22'h0, i[9:0]});
      chk({35'h0, fifo_almost_empty}, {35'h0, i >= 508});
    end
    chk({35'h0, fifo_empty}, 36'h1);
    rd_fifo();
    chk(fifo_rdata, {4'h9, 22'h0, 10'h1FF});
    rdc(erf_pkg::OFS_IRQ_STATUS, 32'hF, 32'hA);
    complete_run();
  end
endmodule : erf_embedded_ram_block_tb
`default_nettype wire
